// ### pkg/qsf_defines.svh
// Purpose: Constants of the serial flash bus front end
// Assumes: sys_clk at 100 MHz
// Notes:   Instruction codes, reset timing
`ifndef QSF_DEFINES_SVH
`define QSF_DEFINES_SVH
`define QSF_OP_READ    8'h03
`define QSF_OP_FAST    8'h0b
`define QSF_OP_DOUT2   8'h3b
`define QSF_OP_DIO2    8'hbb
`define QSF_OP_DOUT4   8'h6b
`define QSF_OP_DIO4    8'heb
`define QSF_OP_WORD4   8'he7
`define QSF_OP_OCT4    8'he3
`define QSF_OP_PROG    8'h02
`define QSF_OP_ERASE   8'h20
`define QSF_OP_WRSTAT  8'h01
`define QSF_OP_ENTER4L 8'h38
`define QSF_OP_EXIT4L  8'hff
`define QSF_OP_RSTEN   8'h66
`define QSF_OP_RST     8'h99
`define QSF_CLK_NS     10
`define QSF_TRST_NS    30000
`define QSF_TRST_CYC   ((`QSF_TRST_NS + `QSF_CLK_NS - 1) / `QSF_CLK_NS)
`define QSF_FULL_KB    14'h2000
`endif

// ### pkg/qsf_pkg.sv
// Purpose: Types of the serial flash bus front end
// Assumes: nothing
// Notes:   States are Gray coded along the usual path
package qsf_pkg;
  typedef enum logic [2:0] {
    QSF_IDLE  = 3'h0,
    QSF_CMD   = 3'h1,
    QSF_ADDR  = 3'h3,
    QSF_DUMMY = 3'h2,
    QSF_DOUT  = 3'h6,
    QSF_DIN   = 3'h7,
    QSF_SKIP  = 3'h5
  } qsf_state_type;
  typedef enum logic [1:0] {QSF_L1 = 2'h0, QSF_L2 = 2'h1, QSF_L4 = 2'h2} qsf_lane_type;
  typedef struct packed {
    logic       rst_n;
    logic       cs_n;
    logic       sclk;
    logic [3:0] dl;
  } qsf_pins_type;
  typedef struct packed {
    logic       quad_enable_bit;
    logic       hold_reset_sel;
    logic [1:0] status_protect_bits;
    logic       protect_complement_bit;
    logic       sector_granularity_bit;
    logic       top_bottom_bit;
    logic [2:0] block_protect;
  } qsf_cfg_type;
  typedef struct packed {
    qsf_state_type st;
    qsf_pins_type  sy1;
    qsf_pins_type  sy2;
    logic          sclk_p;
    logic          cs_p;
    logic          sel;
    logic          hold;
    logic          four_line;
    qsf_lane_type  lanes;
    logic [3:0]    cnt;
    logic [7:0]    shi;
    logic [7:0]    sho;
    logic [7:0]    cmd;
    logic [1:0]    abytes;
    logic [3:0]    dmy;
    logic          rst_armed;
    logic [11:0]   busy;
    logic          cmd_valid;
    logic [23:0]   addr;
    logic          rx_valid;
    logic [7:0]    rx_byte;
    logic          pop;
    logic [3:0]    dl_o;
    logic [3:0]    drv;
    logic [3:0]    dl_oe;
    logic          sr_block;
    logic [13:0]   prot_kb;
    logic          prot_top;
  } qsf_regs_type;
endpackage

// ### hw/qsf_front_end.sv
// Purpose: Serial bus front end of a quad serial flash
// Assumes: sclk, cs_n and data lines come from the host, sampled by sys_clk
// Notes:   Read data comes from a FIFO; received bytes leave as pulses
// Operation
// (R1) Chip select high deselects and releases every driven data line.
// (R2) No instruction until chip select falls after power-up.
// (R3) Single-line mode samples serial_in_line on sclk rising edges.
// (R4) Read data leaves on sclk falling edges on active lines.
// (R5) Only bus modes 0 and 3; clock idle level at select edges.
// (R6) Codes 3Bh and BBh use data lines 0 and 1 both ways; 3Bh takes its address on line 0 alone.
// (R7) Quad reads 6Bh, EBh, E7h, E3h use all four data lines.
// (R8) Quad instructions run only with quad_enable_bit set.
// (R9) Write-protect low with protect bits blocks status writes.
// (R10) Block protect bits choose a region from one sector to all.
// (R11) Hold low while selected floats output, ignores input and clock.
// (R12) Write-protect and hold exist only while quad_enable_bit is clear.
// (R13) Line 3 is hold or reset by a setting when quad disabled.
// (R14) A dedicated reset input works regardless of quad_enable_bit.
// (R15) Code 38h enters four_line_instruction_mode, FFh leaves it.
// (R16) In four_line_instruction_mode the code takes two clocks.
// (R17) Exactly one of the two instruction modes is active.
// (R18) Power-up and software reset start in single-line instruction mode.
// (R19) Entering four_line_instruction_mode needs quad_enable_bit set.
// (R20) Hold acts and releases only while sclk is low.
// (R21) quad_enable_bit clear leaves the shared pin as hold.
// (R22) A setting picks hold or active-low reset for line 3.
// (R23) Reset needs 66h then 99h; commands ignored about 30 us.
// (R24) All fields move most significant bit first.
`include "qsf_defines.svh"

////////////////////////////////////////////////////////////////////////
// Read data buffer
module qsf_fifo
  import qsf_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         s_valid,
  output logic              s_ready,
  input  wire logic [W-1:0] s_data,
  // Drain side
  output logic              m_valid,
  input  wire logic         m_ready,
  output logic [W-1:0]      m_data
);
  localparam int A = $clog2(D);
  typedef struct packed {
    logic [A:0] wp;
    logic [A:0] rp;
    logic       full;
    logic       empty;
  } qsf_fifo_type;
  qsf_fifo_type      q;
  qsf_fifo_type      d;
  logic [W-1:0]      mem [D];
  logic              push;
  logic              pull;
  logic [A:0]        fill;

  assign push    = s_valid & ~q.full;
  assign pull    = m_ready & ~q.empty;
  assign s_ready = ~q.full;
  assign m_valid = ~q.empty;
  assign m_data  = mem[q.rp[A-1:0]];

  // Flags are kept as flops so ready never ripples
  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pull) begin
      d.rp = q.rp + 1'b1;
    end
    fill    = d.wp - d.rp;
    d.full  = fill == (A+1)'(D);
    d.empty = fill == '0;
    if (!rstn) begin
      d = '{wp: '0, rp: '0, full: 1'b0, empty: 1'b1};
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
    if (push) begin
      mem[q.wp[A-1:0]] <= s_data;
    end
  end
endmodule // qsf_fifo

////////////////////////////////////////////////////////////////////////
// Front end
module qsf_front_end
  import qsf_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Bus pins from the host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        rst_pin_n,
  input  wire logic [3:0]  data_line_in,
  output logic [3:0]       data_line_out,
  output logic [3:0]       data_line_oe,
  // Status settings
  input  qsf_cfg_type      cfg,
  // Read data source
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  output logic             rd_ready,
  // Decoded traffic
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [23:0]      addr,
  output logic             rx_valid,
  output logic [7:0]       rx_byte,
  // Mode and protection
  output logic             four_line_instruction_mode,
  output logic             hold_active,
  output logic             reset_busy,
  output logic             status_write_blocked,
  output logic [13:0]      prot_kb,
  output logic             prot_top
);
  localparam qsf_pins_type PIN_IDLE = '{rst_n: 1'b1, cs_n: 1'b0, sclk: 1'b0, dl: 4'hf};
  localparam qsf_regs_type RST = '{sy1: PIN_IDLE, sy2: PIN_IDLE, st: QSF_IDLE,
                                   lanes: QSF_L1, default: '0};
  qsf_regs_type q;
  qsf_regs_type d;
  qsf_pins_type pins;
  qsf_pins_type s;
  logic         rise;
  logic         fall;
  logic         cs_fall;
  logic         hold_fn;
  logic         pin_rst;
  logic [3:0]   step;
  logic [7:0]   nshi;
  logic [3:0]   ncnt;
  logic         byte_done;
  logic         head_valid;
  logic [7:0]   head;
  logic         fifo_ready;

  function automatic logic is_quad(input logic [7:0] c);
    return c == `QSF_OP_DOUT4 || c == `QSF_OP_DIO4 || c == `QSF_OP_WORD4 || c == `QSF_OP_OCT4;
  endfunction

  function automatic logic is_read(input logic [7:0] c);
    return c == `QSF_OP_READ || c == `QSF_OP_FAST || c == `QSF_OP_DOUT2 ||
           c == `QSF_OP_DIO2 || is_quad(c);
  endfunction

  // Dummy clocks between address and data
  function automatic logic [3:0] dummy_of(input logic [7:0] c);
    case (c)
      `QSF_OP_FAST, `QSF_OP_DOUT2, `QSF_OP_DOUT4: return 4'h8;
      `QSF_OP_DIO2, `QSF_OP_WORD4: return 4'h4;
      `QSF_OP_DIO4: return 4'h6;
      `QSF_OP_OCT4: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Read data FIFO, drained one byte per loaded output byte
  qsf_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .s_valid (rd_valid),
    .s_ready (fifo_ready),
    .s_data  (rd_data),
    .m_valid (head_valid),
    .m_ready (q.pop),
    .m_data  (head)
  );

  ////////////////////////////////////////////////////////////////////
  // Edge finding on the synchronised pins
  assign pins    = '{rst_n: rst_pin_n, cs_n: cs_n, sclk: sclk, dl: data_line_in};
  assign s       = q.sy2;
  assign cs_fall = ~s.cs_n & q.cs_p;                                  // R2
  // Held or deselected cycles see no clock edges
  assign rise    = s.sclk & ~q.sclk_p & q.sel & ~q.hold & ~s.cs_n;    // R3 R11
  assign fall    = ~s.sclk & q.sclk_p & q.sel & ~q.hold & ~s.cs_n;    // R4 R11
  assign hold_fn = ~cfg.quad_enable_bit & ~cfg.hold_reset_sel;       // R12 R21 R22
  // Dedicated pin always resets; shared line only as reset role
  assign pin_rst = ~s.rst_n |                                         // R14
                   (~cfg.quad_enable_bit & cfg.hold_reset_sel & ~s.dl[3]); // R13 R22
  assign step    = (q.lanes == QSF_L1) ? 4'h1 : (q.lanes == QSF_L2) ? 4'h2 : 4'h4;
  assign ncnt    = q.cnt + step;
  assign byte_done = ncnt == 4'h8;

  // Input shift, first bit received lands highest
  always_comb begin
    unique case (q.lanes)
      QSF_L1:  nshi = {q.shi[6:0], s.dl[0]};                         // R3 R24
      QSF_L2:  nshi = {q.shi[5:0], s.dl[1:0]};                       // R6
      default: nshi = {q.shi[3:0], s.dl};                            // R7 R16
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d           = q;
    d.sy1       = pins;
    d.sy2       = q.sy1;
    d.sclk_p    = s.sclk;
    d.cs_p      = s.cs_n;
    d.cmd_valid = 1'b0;
    d.rx_valid  = 1'b0;
    d.pop       = 1'b0;
    if (q.busy != 12'h000) begin
      d.busy = q.busy - 12'h001;
    end
    // Protection follows the settings and the write-protect pin
    d.sr_block = ~cfg.quad_enable_bit & ~s.dl[2] & cfg.status_protect_bits[0]; // R9 R12
    d.prot_top = ~cfg.top_bottom_bit;
    if (cfg.block_protect == 3'h0) begin                               // R10
      d.prot_kb = 14'h0000;
    end else if (cfg.block_protect == 3'h7) begin
      d.prot_kb = `QSF_FULL_KB;
    end else if (cfg.sector_granularity_bit) begin
      d.prot_kb = (cfg.block_protect > 3'h4) ? 14'h0020 : 14'h0004 << (cfg.block_protect - 3'h1);
    end else begin
      d.prot_kb = 14'h0040 << (cfg.block_protect - 3'h1);
    end
    if (cfg.protect_complement_bit) begin
      d.prot_kb = `QSF_FULL_KB - d.prot_kb;
    end
    // Hold follows line 3 only while sclk is low, so a high clock waits for its fall; deselect or loss of the hold role clears it at once
    if (!s.cs_n && hold_fn && !s.sclk) begin                          // R20
      d.hold = ~s.dl[3];                                              // R11
    end else if (s.cs_n || !hold_fn) begin
      d.hold = 1'b0;
    end
    if (s.cs_n) begin                                                 // R1
      d.sel = 1'b0;
      d.st  = QSF_IDLE;
      d.drv = 4'h0;
    end else if (cs_fall && q.busy == 12'h000) begin                  // R2 R23
      // Clock idle level is free at select, so modes 0 and 3 both work
      d.sel   = 1'b1;                                                 // R5
      d.st    = QSF_CMD;
      d.cnt   = 4'h0;
      d.lanes = q.four_line ? QSF_L4 : QSF_L1;                        // R16
    end else begin
      unique case (q.st)
        QSF_CMD: begin
          if (rise) begin
            d.shi = nshi;
            d.cnt = ncnt;
            if (byte_done) begin
              d.cnt       = 4'h0;
              d.cmd       = nshi;
              d.cmd_valid = 1'b1;
              d.rst_armed = nshi == `QSF_OP_RSTEN;                    // R23
              d.dmy       = dummy_of(nshi);
              d.abytes    = 2'h2;
              d.st        = QSF_DIN;
              d.lanes     = q.four_line ? QSF_L4 : QSF_L1;
              if (is_quad(nshi) && !cfg.quad_enable_bit) begin        // R8
                d.st = QSF_SKIP;
              end else if (is_read(nshi) || nshi == `QSF_OP_PROG ||
                           nshi == `QSF_OP_ERASE) begin
                d.st = QSF_ADDR;
                if (!q.four_line && nshi == `QSF_OP_DIO2) begin
                  d.lanes = QSF_L2;                                   // R6
                end else if (!q.four_line && (nshi == `QSF_OP_DIO4 ||
                             nshi == `QSF_OP_WORD4 || nshi == `QSF_OP_OCT4)) begin
                  d.lanes = QSF_L4;                                   // R7
                end
              end else if (nshi == `QSF_OP_WRSTAT && q.sr_block) begin
                d.st = QSF_SKIP;                                      // R9
              end else if (nshi == `QSF_OP_ENTER4L) begin
                d.four_line = cfg.quad_enable_bit;                    // R15 R17 R19
                d.st        = QSF_SKIP;
              end else if (nshi == `QSF_OP_EXIT4L) begin
                d.four_line = 1'b0;                                   // R15 R17
                d.st        = QSF_SKIP;
              end else if (nshi == `QSF_OP_RSTEN) begin
                d.st = QSF_SKIP;
              end else if (nshi == `QSF_OP_RST) begin
                d.st = QSF_SKIP;
                if (q.rst_armed) begin
                  d.four_line = 1'b0;                                 // R18
                  d.busy      = 12'(`QSF_TRST_CYC);                   // R23
                end
              end
            end
          end
        end
        QSF_ADDR: begin
          if (rise) begin
            d.shi = nshi;
            d.cnt = ncnt;
            if (byte_done) begin
              d.cnt    = 4'h0;
              d.addr   = {q.addr[15:0], nshi};                        // R24
              d.abytes = q.abytes - 2'h1;
              if (q.abytes == 2'h0) begin
                if (!is_read(q.cmd)) begin
                  d.st    = QSF_DIN;
                  d.lanes = q.four_line ? QSF_L4 : QSF_L1;
                end else if (q.dmy != 4'h0) begin
                  d.st = QSF_DUMMY;
                end else begin
                  d.st = QSF_DOUT;
                end
              end
            end
          end
        end
        QSF_DUMMY: begin
          if (rise) begin
            d.dmy = q.dmy - 4'h1;
            if (q.dmy == 4'h1) begin
              d.st = QSF_DOUT;
            end
          end
        end
        QSF_DOUT: begin
          if (fall) begin                                             // R4
            unique case (q.lanes)
              QSF_L1: begin
                d.dl_o = {2'h0, q.sho[7], 1'b0};
                d.drv  = 4'h2;
              end
              QSF_L2: begin
                d.dl_o = {2'h0, q.sho[7:6]};                          // R6
                d.drv  = 4'h3;
              end
              default: begin
                d.dl_o = q.sho[7:4];                                  // R7
                d.drv  = 4'hf;
              end
            endcase
            d.sho = q.sho << step;                                    // R24
            d.cnt = ncnt;
            if (byte_done) begin
              d.cnt = 4'h0;
              d.sho = head_valid ? head : 8'h00;
              d.pop = head_valid;
            end
          end
        end
        QSF_DIN: begin
          if (rise) begin
            d.shi = nshi;
            d.cnt = ncnt;
            if (byte_done) begin
              d.cnt      = 4'h0;
              d.rx_valid = 1'b1;
              d.rx_byte  = nshi;
            end
          end
        end
        default: begin
        end
      endcase
      // First output byte is taken on the way into the data phase
      if (d.st == QSF_DOUT && q.st != QSF_DOUT) begin
        d.cnt   = 4'h0;
        d.sho   = head_valid ? head : 8'h00;
        d.pop   = head_valid;
        d.lanes = (q.four_line || is_quad(q.cmd)) ? QSF_L4 :
                  (q.cmd == `QSF_OP_DOUT2 || q.cmd == `QSF_OP_DIO2) ? QSF_L2 : QSF_L1;
      end
    end
    // Pin reset restarts all but the synchronisers, edge history and read FIFO
    if (pin_rst) begin
      d        = RST;
      d.sy1    = pins;
      d.sy2    = q.sy1;
      d.sclk_p = s.sclk;
      d.cs_p   = s.cs_n;
    end
    d.dl_oe = (d.hold || s.cs_n || pin_rst) ? 4'h0 : d.drv;          // R1 R11
    if (!rstn) begin
      d = RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    q <= d;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign data_line_out              = q.dl_o;
  assign data_line_oe               = q.dl_oe;
  assign rd_ready                   = fifo_ready;
  assign cmd_valid                  = q.cmd_valid;
  assign cmd_code                   = q.cmd;
  assign addr                       = q.addr;
  assign rx_valid                   = q.rx_valid;
  assign rx_byte                    = q.rx_byte;
  assign four_line_instruction_mode = q.four_line;
  assign hold_active                = q.hold;
  assign reset_busy                 = q.busy != 12'h000;
  assign status_write_blocked       = q.sr_block;
  assign prot_kb                    = q.prot_kb;
  assign prot_top                   = q.prot_top;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  desel_float_a: assert property (s.cs_n |=> q.dl_oe == 4'h0) // R1
    else $error("lines driven while deselected");
  select_edge_a: assert property ($rose(q.sel) |-> $past(q.cs_p) && !$past(s.cs_n)) // R2
    else $error("select without chip select fall");
  rise_sample_a: assert property ((rise && q.st == QSF_CMD && q.lanes == QSF_L1) // R3
    |=> q.shi[0] == $past(s.dl[0]))
    else $error("input bit not sampled on rise");
  fall_drive_a: assert property ($changed(q.dl_o) && !$past(pin_rst) |-> $past(fall)) // R4
    else $error("output changed off a falling edge");
  quad_gate_a: assert property (q.drv == 4'hf |-> cfg.quad_enable_bit || q.four_line) // R8
    else $error("four lines driven without quad enable");
  hold_float_a: assert property (q.hold |-> q.dl_oe == 4'h0) // R11
    else $error("output driven during hold");
  hold_timing_a: assert property ($changed(q.hold) && !q.sy2.cs_n && !$past(s.cs_n)
    && !$past(pin_rst) |-> !$past(s.sclk)) // R20
    else $error("hold moved while clock high");
  four_entry_a: assert property ($rose(q.four_line) |-> $past(cfg.quad_enable_bit)) // R19
    else $error("four-line mode without quad enable");
  busy_block_a: assert property (reset_busy |=> !$rose(q.sel)) // R23
    else $error("selected during reset period");
  sw_reset_a: assert property ($rose(reset_busy) |-> !q.four_line ##1 !q.four_line) // R18
    else $error("software reset left four-line mode");
  sr_block_a: assert property ((q.sr_block && q.st == QSF_CMD && rise && byte_done
    && nshi == `QSF_OP_WRSTAT) |=> q.st == QSF_SKIP) // R9
    else $error("status write not blocked");

  dual_read_c: cover property (q.st == QSF_DOUT && q.lanes == QSF_L2);
  quad_read_c: cover property (q.st == QSF_DOUT && q.lanes == QSF_L4);
  four_line_c: cover property ($rose(q.four_line));
  hold_c:      cover property ($rose(q.hold) ##[1:200] $fell(q.hold));
endmodule // qsf_front_end

// ### sim/qsf_host.sv
// Purpose: Host bus master model for the flash front end
// Assumes: Mode 0; mode 3 by raising sclk, 125 ns serial clock
// Notes:   Lines 2 and 3 idle high as if pulled up
module qsf_host (
  // Bus pins toward the device
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] dl_h,
  // Resolved wire levels
  input  wire logic [3:0] dl_w
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus: deselected, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dl_h = 4'hf;
  end
  // Select edge half a clock period in; sclk left as it is
  task automatic sel(input logic s);
    #62.5 cs_n = ~s;
    #62.5;
  endtask
  // Clock pulses, data held meanwhile
  task automatic clk(input int n);
    repeat (n) begin
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
  endtask
  // Byte out on n lines, msb first
  task automatic send(input logic [7:0] v, input int n);
    repeat (8 / n) begin
      if (n == 4) dl_h = v[7:4];
      else if (n == 2) dl_h[1:0] = v[7:6];
      else dl_h[0] = v[7];
      v = v << n;
      clk(1);
    end
    dl_h = 4'hf;
  endtask
  // Byte in on rising edges, msb first
  task automatic recv(input int n, output logic [7:0] v);
    v = 8'h00;
    repeat (8 / n) begin
      #62.5 sclk = 1'b1;
      v = (n == 4) ? {v[3:0], dl_w} :
          (n == 2) ? {v[5:0], dl_w[1:0]} : {v[6:0], dl_w[1]};
      #62.5 sclk = 1'b0;
    end
  endtask
endmodule // qsf_host

// ### sim/quad_serial_flash_bus_front_end_tb.sv
// Purpose: Self-checking bench of the flash front end
// Assumes: Host model drives the link unrelated to sys_clk
// Notes:   Bench inputs change on rising sys_clk edges
module quad_serial_flash_bus_front_end_tb
  import qsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        rst_pin_n = 1'b1;
  logic        rd_valid = 1'b0;
  logic [7:0]  rd_data = 8'h00;
  qsf_cfg_type cfg = '0;
  logic        sclk, cs_n, cmd_valid, rx_valid, flm, hold_active, reset_busy, swb;
  logic        prot_top, rd_ready;
  logic [3:0]  dl_h, dl_o, dl_oe, dl_w;
  logic [7:0]  cmd_code, rx_byte, b, rx_last;
  logic [23:0] addr;
  logic [13:0] prot_kb;
  int          err_total = 0;
  int          compares = 0;
  int          rx_cnt = 0, cmd_cnt = 0;
  // Clock; the device wins each line it drives
  always #5 sys_clk = ~sys_clk;
  assign dl_w = (dl_oe & dl_o) | (~dl_oe & dl_h);
  // Tally pulses; at the edge the launched value is read
  always @(posedge sys_clk) begin
    rx_cnt += (rx_valid === 1'b1);
    cmd_cnt += (cmd_valid === 1'b1);
    if (rx_valid === 1'b1) rx_last = rx_byte;
  end
  ////////////////////////////////////////////////////////////////////////
  qsf_front_end #(.FIFO_DEPTH(16)) qsf_front_end_inst (
    .sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .rst_pin_n(rst_pin_n),
    .data_line_in(dl_w), .data_line_out(dl_o), .data_line_oe(dl_oe), .cfg(cfg),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .addr(addr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .four_line_instruction_mode(flm), .hold_active(hold_active),
    .reset_busy(reset_busy), .status_write_blocked(swb), .prot_kb(prot_kb),
    .prot_top(prot_top));
  qsf_host qsf_host_inst (.sclk(sclk), .cs_n(cs_n), .dl_h(dl_h), .dl_w(dl_w));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    if (err_total == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One byte into the read buffer
  task automatic push(input logic [7:0] d);
    @(posedge sys_clk);
    rd_valid <= 1'b1;
    rd_data <= d;
    @(posedge sys_clk);
    rd_valid <= 1'b0;
  endtask
  // Instruction-only frame
  task automatic op(input logic [7:0] c, input int n);
    qsf_host_inst.sel(1'b1);
    qsf_host_inst.send(c, n);
    qsf_host_inst.sel(1'b0);
  endtask
  // Read frame up to the first byte; caller deselects
  task automatic rd(input logic [7:0] c, input int al, input int dm, input int dn);
    qsf_host_inst.sel(1'b1);
    qsf_host_inst.send(c, 1);
    for (int i = 0; i < 3; i++) qsf_host_inst.send(8'h12 + 8'(i * 34), al);
    qsf_host_inst.clk(dm);
    qsf_host_inst.recv(dn, b);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Fill the buffer until refused, drain it by one long read
  task automatic t_read;
    for (int i = 0; i < 16; i++) push(8'ha0 + 8'(i));
    repeat (2) @(posedge sys_clk);
    chk("full", 1'b0, rd_ready);
    rd(8'h03, 1, 0, 1);
    chk("cmd", 8'h03, cmd_code);
    chk("addr", 24'h123456, addr);
    chk("oe", 4'h2, dl_oe);
    for (int i = 0; i < 16; i++) begin
      chk("data", 8'ha0 + 8'(i), b);
      qsf_host_inst.recv(1, b);
    end
    chk("empty", 8'h00, b);
    chk("space", 1'b1, rd_ready);
    qsf_host_inst.sel(1'b0);
    chk("oe off", 4'h0, dl_oe);
  endtask
  // Quad refused without the enable bit, then every multi-line read
  task automatic t_modes;
    logic [7:0] c [6] = '{8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7, 8'he3};
    int al [6] = '{1, 2, 1, 4, 4, 4};
    int dm [6] = '{8, 4, 8, 6, 4, 2};
    rd(8'h6b, 1, 8, 4);
    chk("refused", 4'h0, dl_oe);
    qsf_host_inst.sel(1'b0);
    op(8'h38, 1);
    chk("no 4line", 1'b0, flm);
    @(posedge sys_clk) cfg.quad_enable_bit <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      push(c[i] ^ 8'h5a);
      rd(c[i], al[i], dm[i], i < 2 ? 2 : 4);
      chk("lanes", c[i] ^ 8'h5a, b);
      qsf_host_inst.sel(1'b0);
    end
    qsf_host_inst.sclk = 1'b1; // Mode 3 frame, clock high at select edges
    qsf_host_inst.sel(1'b1);
    qsf_host_inst.sclk = 1'b0;
    qsf_host_inst.send(8'h38, 1);
    #62.5 qsf_host_inst.sclk = 1'b1;
    qsf_host_inst.sel(1'b0);
    qsf_host_inst.sclk = 1'b0;
    chk("4line", 1'b1, flm);
    op(8'hff, 4);
    chk("exit", 1'b0, flm);
  endtask
  // Software reset, busy period, then the dedicated reset pin
  task automatic t_reset;
    op(8'h38, 1);
    op(8'h66, 4);
    op(8'h99, 4);
    chk("busy", 1'b1, reset_busy);
    chk("mode", 1'b0, flm);
    op(8'h38, 1);
    chk("ignored", 1'b0, flm);
    for (int i = 0; i < 3500 && reset_busy === 1'b1; i++) @(posedge sys_clk);
    chk("busy end", 1'b0, reset_busy);
    op(8'h38, 1);
    chk("4line", 1'b1, flm);
    @(posedge sys_clk) rst_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("pin", 1'b0, flm);
    rst_pin_n <= 1'b1;
  endtask
  // Hold on line 3 with the clock low, then write protect
  task automatic t_pins;
    op(8'h38, 1);
    chk("4line", 1'b1, flm);
    @(posedge sys_clk) cfg.quad_enable_bit <= 1'b0;
    cfg.hold_reset_sel <= 1'b1;
    cfg.status_protect_bits <= 2'b01;
    cfg.block_protect <= 3'h7;
    qsf_host_inst.dl_h[3] = 1'b0;
    #100;
    chk("line rst", 1'b0, flm);
    qsf_host_inst.dl_h[3] = 1'b1;
    @(posedge sys_clk) cfg.hold_reset_sel <= 1'b0;
    qsf_host_inst.sel(1'b1);
    qsf_host_inst.dl_h[3] = 1'b0;
    qsf_host_inst.dl_h[2] = 1'b0;
    #100;
    chk("hold", 1'b1, hold_active);
    chk("wp", 1'b1, swb);
    chk("full", 14'h2000, prot_kb);
    qsf_host_inst.dl_h = 4'hf;
    #100;
    chk("resume", 1'b0, hold_active);
    chk("wp off", 1'b0, swb);
    qsf_host_inst.sel(1'b0);
    @(posedge sys_clk) cfg <= 10'h07a; // Complemented 8 KB span at bottom
    repeat (2) @(posedge sys_clk);
    chk("span", 14'h1ff8, prot_kb);
    chk("top", 1'b0, prot_top);
  endtask
  // Code then one data byte on line 0
  task automatic wr(input logic [7:0] c, input logic [7:0] v);
    qsf_host_inst.sel(1'b1);
    qsf_host_inst.send(c, 1);
    qsf_host_inst.send(v, 1);
    qsf_host_inst.sel(1'b0);
  endtask
  // Status write refused under write protect, taken once released
  task automatic t_write;
    int n = rx_cnt;
    int m = cmd_cnt;
    qsf_host_inst.dl_h[2] = 1'b0;
    wr(8'h01, 8'hc3);
    chk("blocked", n, rx_cnt);
    wr(8'h01, 8'h5a);
    chk("rx", n + 1, rx_cnt);
    chk("rx byte", 8'h5a, rx_last);
    chk("cmds", m + 2, cmd_cnt);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("oe", 4'h0, dl_oe);
    chk("mode", 1'b0, flm);
    t_read;
    t_modes;
    t_reset;
    t_pins;
    t_write;
    wrap_up;
  end
  // Watchdog well past the expected 93 us
  initial begin
    #400us;
    err_total++;
    wrap_up;
  end
endmodule // quad_serial_flash_bus_front_end_tb
